// [core/gdc_i2c_slave.sv]
// gdc_i2c_slave: two-wire slave with eight channels and control register
// assumes: scl/sda from pins, far slower than clk_in; sda is open drain
//
// Operation
// - control register at 08h, zero after every reset.
// - control bit 7 selects working-only writes; bits 6..0 reserved.
// - sda falling while scl high is a start; slave detects it.
// - sda rising while scl high is a stop; transaction ends.
// - repeated start restarts the transfer like a plain start.
// - incoming bits are sampled on scl rising edge.
// - outgoing bits change after scl falling edge.
// - ninth bit of every byte is acknowledge, low means ack.
// - written bytes received msb first, then slave acknowledges.
// - read bytes sent msb first; master nack ends, slave releases sda.
// - first byte holds 7-bit address and read/write flag in bit 0.
// - one address bit follows the strap pin.
// - flag 0 is write, 1 is read; E8h/E9h with strap low.
// - address mismatch means ignore everything until next start.
// - byte after address byte in a write is the memory address.
// - channel reads always return working storage.
// - channel values reach outputs after stop; nv write then if bit 7 low.
// - write address counter wraps within its 4-byte page.
// - while nv programming runs, own address is not acknowledged.
`timescale 1ns/100ps
`default_nettype none
module gdc_i2c_slave (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // serial pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_oe_n_out,
    // strap
    input wire logic addr_strap_pin_in,
    // channel outputs and nv port
    output logic [63:0] channel_out,
    output logic nv_busy_out,
    output logic nv_write_out,
    output logic [63:0] nv_data_out,
    output logic [7:0] write_target_control_out
);
    localparam int NV_CNT_W_L = gdc_pkg::NV_CNT_W;
    gdc_pkg::gdc_bus_s meta_q, sync_q, prev_q;
    gdc_pkg::gdc_state_e state_q;
    logic [7:0] shift_q, mem_addr_q, ctrl_q, tx_q;
    logic [3:0] bit_cnt_q;
    logic [1:0] byte_idx_q;
    logic [1:0] strap_q;
    logic rw_q, matched_q, ack_ok_q, dirty_q;
    logic [7:0] work_q [8];
    logic [NV_CNT_W_L-1:0] nv_cnt_q;
    logic scl_rise, scl_fall, start_det, stop_det;
    logic [7:0] rx_byte;
    logic [6:0] own_addr;

    function automatic logic [7:0] page_next(input logic [7:0] a);
        page_next = {a[7:2], a[1:0] + 2'b01};
    endfunction

    function automatic logic [7:0] read_value(input logic [7:0] a,
                                              input logic [7:0] c);
        if (a <= gdc_pkg::CHAN_LAST_ADDR)
            read_value = 8'h00;
        else if (a == gdc_pkg::CTRL_ADDR)
            read_value = c & 8'h80;
        else
            read_value = gdc_pkg::READ_FILL;
    endfunction

    // pins pass two flops before any logic reads them
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            meta_q <= '{scl: 1'b1, sda: 1'b1};
            sync_q <= '{scl: 1'b1, sda: 1'b1};
            prev_q <= '{scl: 1'b1, sda: 1'b1};
            strap_q <= 2'b00;
        end else begin
            meta_q <= '{scl: scl_in, sda: sda_in};
            sync_q <= meta_q;
            prev_q <= sync_q;
            strap_q <= {strap_q[0], addr_strap_pin_in};
        end
    end

    assign scl_rise = sync_q.scl & ~prev_q.scl;
    assign scl_fall = ~sync_q.scl & prev_q.scl;
    assign start_det = prev_q.scl & sync_q.scl & prev_q.sda & ~sync_q.sda;
    assign stop_det = prev_q.scl & sync_q.scl & ~prev_q.sda & sync_q.sda;
    assign rx_byte = {shift_q[6:0], sync_q.sda};
    assign own_addr = {gdc_pkg::SLAVE_ADDR_HI, 1'b0} | {6'h00, strap_q[1]};

    // bit and byte sequencing
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_q <= gdc_pkg::GDC_IDLE;
            bit_cnt_q <= 4'h0;
            byte_idx_q <= 2'd0;
            shift_q <= 8'h00;
            rw_q <= 1'b0;
            matched_q <= 1'b0;
            ack_ok_q <= 1'b0;
            tx_q <= 8'h00;
        end else if (start_det) begin
            state_q <= gdc_pkg::GDC_RECV;
            bit_cnt_q <= 4'h0;
            byte_idx_q <= 2'd0;
            matched_q <= 1'b0;
        end else if (stop_det) begin
            state_q <= gdc_pkg::GDC_IDLE;
            matched_q <= 1'b0;
        end else begin
            unique case (state_q)
                gdc_pkg::GDC_IDLE: ;
                gdc_pkg::GDC_RECV: begin
                    if (scl_rise) begin
                        shift_q <= rx_byte;
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == 4'h8) begin
                        bit_cnt_q <= 4'h0;
                        if (byte_idx_q == 2'd0) begin
                            ack_ok_q <= shift_q[7:1] == own_addr && !nv_busy_out;
                            matched_q <= shift_q[7:1] == own_addr && !nv_busy_out;
                            rw_q <= shift_q[0];
                            state_q <= (shift_q[7:1] == own_addr && !nv_busy_out)
                                ? gdc_pkg::GDC_ACK : gdc_pkg::GDC_IDLE;
                        end else begin
                            ack_ok_q <= 1'b1;
                            state_q <= gdc_pkg::GDC_ACK;
                        end
                    end
                end
                gdc_pkg::GDC_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_q <= 4'h0;
                        if (byte_idx_q != 2'd2)
                            byte_idx_q <= byte_idx_q + 2'd1;
                        if (rw_q) begin
                            tx_q <= read_value(mem_addr_q, ctrl_q);
                            state_q <= gdc_pkg::GDC_SEND;
                        end else begin
                            state_q <= gdc_pkg::GDC_RECV;
                        end
                    end
                end
                gdc_pkg::GDC_SEND: begin
                    if (scl_fall) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        tx_q <= {tx_q[6:0], 1'b0};
                        if (bit_cnt_q == 4'h7)
                            state_q <= gdc_pkg::GDC_MACK;
                    end
                end
                gdc_pkg::GDC_MACK: begin
                    if (scl_rise)
                        ack_ok_q <= ~sync_q.sda;
                    else if (scl_fall) begin
                        bit_cnt_q <= 4'h0;
                        tx_q <= read_value(mem_addr_q, ctrl_q);
                        state_q <= ack_ok_q ? gdc_pkg::GDC_SEND
                                            : gdc_pkg::GDC_IDLE;
                    end
                end
                default: state_q <= gdc_pkg::GDC_IDLE;
            endcase
        end
    end

    // address counter, storage and control register
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            mem_addr_q <= 8'h00;
            ctrl_q <= gdc_pkg::CTRL_RESET;
            dirty_q <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                work_q[i] <= gdc_pkg::CHAN_RESET;
            end
        end else if (state_q == gdc_pkg::GDC_RECV && scl_fall && bit_cnt_q == 4'h8
                     && byte_idx_q != 2'd0) begin
            if (byte_idx_q == 2'd1) begin
                mem_addr_q <= shift_q;
            end else begin
                if (mem_addr_q <= gdc_pkg::CHAN_LAST_ADDR) begin
                    work_q[mem_addr_q[2:0]] <= shift_q;
                    dirty_q <= 1'b1;
                end else if (mem_addr_q == gdc_pkg::CTRL_ADDR) begin
                    ctrl_q <= shift_q & 8'h80;
                end
                mem_addr_q <= page_next(mem_addr_q);
            end
        end else if (state_q == gdc_pkg::GDC_SEND && scl_fall && bit_cnt_q == 4'h7) begin
            mem_addr_q <= mem_addr_q + 8'h01;
        end else if (stop_det) begin
            dirty_q <= 1'b0;
        end
    end

    // outgoing read data needs working storage, patched in here
    logic [7:0] tx_bit_src;
    assign tx_bit_src = (mem_addr_q <= gdc_pkg::CHAN_LAST_ADDR)
        ? work_q[mem_addr_q[2:0]] : read_value(mem_addr_q, ctrl_q);
    logic tx_chan_q;
    always_ff @(posedge clk_in) begin
        if (srst_in)
            tx_chan_q <= 1'b0;
        else if ((state_q == gdc_pkg::GDC_ACK || state_q == gdc_pkg::GDC_MACK) && scl_fall)
            tx_chan_q <= (mem_addr_q <= gdc_pkg::CHAN_LAST_ADDR);
        else if (state_q == gdc_pkg::GDC_IDLE)
            tx_chan_q <= 1'b0;
    end
    logic [7:0] tx_work_q;
    always_ff @(posedge clk_in) begin
        if (srst_in)
            tx_work_q <= 8'h00;
        else if ((state_q == gdc_pkg::GDC_ACK || state_q == gdc_pkg::GDC_MACK) && scl_fall)
            tx_work_q <= tx_bit_src;
        else if (state_q == gdc_pkg::GDC_SEND && scl_fall)
            tx_work_q <= {tx_work_q[6:0], 1'b0};
    end

    // sda: low enable means driving low
    always_ff @(posedge clk_in) begin
        if (srst_in)
            sda_oe_n_out <= 1'b1;
        else if (start_det || stop_det)
            sda_oe_n_out <= 1'b1;
        else if (scl_fall) begin
            if (state_q == gdc_pkg::GDC_RECV && bit_cnt_q == 4'h8)
                sda_oe_n_out <= !((byte_idx_q != 2'd0 && matched_q)
                    || (shift_q[7:1] == own_addr && !nv_busy_out));
            else if (state_q == gdc_pkg::GDC_ACK && rw_q)
                sda_oe_n_out <= tx_bit_src[7];
            else if (state_q == gdc_pkg::GDC_SEND && bit_cnt_q != 4'h7)
                sda_oe_n_out <= tx_chan_q ? tx_work_q[6] : tx_q[6];
            else if (state_q == gdc_pkg::GDC_MACK && ack_ok_q)
                sda_oe_n_out <= tx_bit_src[7];
            else
                sda_oe_n_out <= 1'b1;
        end
    end

    // output update and nv programming after stop
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            channel_out <= {8{gdc_pkg::CHAN_RESET}};
            nv_data_out <= {8{gdc_pkg::CHAN_RESET}};
            nv_write_out <= 1'b0;
            nv_busy_out <= 1'b0;
            nv_cnt_q <= '0;
        end else begin
            nv_write_out <= 1'b0;
            if (stop_det && dirty_q) begin
                for (int i = 0; i < 8; i++) begin
                    channel_out[i*8 +: 8] <= work_q[i];
                end
                if (!ctrl_q[gdc_pkg::CTRL_TARGET_BIT]) begin
                    for (int i = 0; i < 8; i++) begin
                        nv_data_out[i*8 +: 8] <= work_q[i];
                    end
                    nv_write_out <= 1'b1;
                    nv_busy_out <= 1'b1;
                    nv_cnt_q <= NV_CNT_W_L'(gdc_pkg::NV_WRITE_CYCLES - 1);
                end
            end else if (nv_busy_out) begin
                if (nv_cnt_q == '0)
                    nv_busy_out <= 1'b0;
                else
                    nv_cnt_q <= nv_cnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in)
            write_target_control_out <= gdc_pkg::CTRL_RESET;
        else
            write_target_control_out <= ctrl_q;
    end

    // master nack releases the line within one falling edge
    property p_nack_release;
        @(posedge clk_in) disable iff (srst_in)
        (state_q == gdc_pkg::GDC_MACK && !ack_ok_q && scl_fall) |=> sda_oe_n_out;
    endproperty
    a_nack_release: assert property (p_nack_release) else $error("sda held after nack");

    property p_stop_idle;
        @(posedge clk_in) disable iff (srst_in)
        stop_det && !start_det |=> state_q == gdc_pkg::GDC_IDLE && sda_oe_n_out;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");

    property p_start_recv;
        @(posedge clk_in) disable iff (srst_in)
        start_det |=> state_q == gdc_pkg::GDC_RECV && bit_cnt_q == 4'h0;
    endproperty
    a_start_recv: assert property (p_start_recv) else $error("start missed");

    property p_reserved_zero;
        @(posedge clk_in) disable iff (srst_in)
        ctrl_q[6:0] == 7'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

    property p_idle_silent;
        @(posedge clk_in) disable iff (srst_in)
        state_q == gdc_pkg::GDC_IDLE ##1 state_q == gdc_pkg::GDC_IDLE |-> sda_oe_n_out;
    endproperty
    a_idle_silent: assert property (p_idle_silent) else $error("driving while idle");

    property p_sram_only;
        @(posedge clk_in) disable iff (srst_in)
        stop_det && ctrl_q[7] |=> !nv_write_out;
    endproperty
    a_sram_only: assert property (p_sram_only) else $error("nv write in mode 1");

    property p_busy_noack;
        @(posedge clk_in) disable iff (srst_in)
        (nv_busy_out && state_q == gdc_pkg::GDC_RECV && byte_idx_q == 2'd0
         && bit_cnt_q == 4'h8 && scl_fall) |=> sda_oe_n_out;
    endproperty
    a_busy_noack: assert property (p_busy_noack) else $error("acked while busy");

    property p_page_wrap;
        @(posedge clk_in) disable iff (srst_in)
        (state_q == gdc_pkg::GDC_RECV && scl_fall && bit_cnt_q == 4'h8 && byte_idx_q == 2'd2)
        |=> mem_addr_q[7:2] == $past(mem_addr_q[7:2]);
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("left page");
endmodule
`default_nettype wire

// [pkg/gdc_pkg.sv]
// gdc_pkg: constants and types for the gamma reference serial slave
// assumes: one 100 MHz clock, synchronous active-high reset
package gdc_pkg;
    localparam logic [7:0] CTRL_ADDR = 8'h08;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int CTRL_TARGET_BIT = 7;
    localparam logic [7:0] CHAN_LAST_ADDR = 8'h07;
    localparam logic [7:0] CHAN_RESET = 8'h80;
    localparam logic [5:0] SLAVE_ADDR_HI = 6'h3A;
    localparam logic [7:0] READ_FILL = 8'h00;
    localparam int NV_WRITE_NS = 10000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int NV_WRITE_CYCLES = NV_WRITE_NS / CLK_PERIOD_NS;
    localparam int NV_CNT_W = 16;

    typedef enum logic [4:0] {
        GDC_IDLE = 5'b00001,
        GDC_RECV = 5'b00010,
        GDC_ACK = 5'b00100,
        GDC_SEND = 5'b01000,
        GDC_MACK = 5'b10000
    } gdc_state_e;

    typedef struct packed {
        logic scl;
        logic sda;
    } gdc_bus_s;
endpackage

// [testbench/gdc_master_model.sv]
// gdc_master_model: behavioural two-wire bus master for the bench
// assumes: sda_in is the resolved open-drain level; scl is driven push-pull
`timescale 1ns/100ps
`default_nettype none
module gdc_master_model (
    // pacing clock
    input wire logic clk_in,
    // bus
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    // quarter bit of 4 clocks gives a 160 ns scl period
    task automatic quarter;
        repeat (4) @(negedge clk_in);
    endtask
    // sda moves only while scl is low; a 1 releases it for slave bits
    task automatic bit_x(input logic b, output logic r);
        sda_out = b;
        quarter();
        scl_out = 1'b1;
        quarter();
        r = sda_in;
        quarter();
        scl_out = 1'b0;
        quarter();
    endtask
    // works from idle and as a repeated start in mid-transfer
    task automatic start;
        sda_out = 1'b1;
        quarter();
        scl_out = 1'b1;
        quarter();
        sda_out = 1'b0;
        quarter();
        scl_out = 1'b0;
        quarter();
    endtask
    // scl is left high afterwards: no pulses outside frames
    task automatic stop;
        sda_out = 1'b0;
        quarter();
        scl_out = 1'b1;
        quarter();
        sda_out = 1'b1;
        quarter();
    endtask
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(b[i], r);
        end
        bit_x(1'b1, ack);
    endtask
    task automatic rd_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(nack, r);
    endtask
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
endmodule
`default_nettype wire

// [testbench/test_gdc_i2c_slave.sv]
// test_gdc_i2c_slave: self-checking bench for the two-wire slave
// assumes: gdc_master_model owns the bus; sda has a pull-up
`timescale 1ns/100ps
`default_nettype none
module test_gdc_i2c_slave;
    logic clk_in, srst_in, strap, scl, m_sda, sda_oe_n, nv_busy, nv_write;
    logic [63:0] chan, nv_data;
    logic [7:0] ctrl;
    int err_total, samples_checked, nv_pulses;
    wire logic sda;
    assign sda = m_sda & sda_oe_n;

    gdc_master_model gdc_master_model_i (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
        .sda_out(m_sda));
    gdc_i2c_slave gdc_i2c_slave_i (.clk_in(clk_in), .srst_in(srst_in), .scl_in(scl),
        .sda_in(sda), .sda_oe_n_out(sda_oe_n), .addr_strap_pin_in(strap),
        .channel_out(chan), .nv_busy_out(nv_busy), .nv_write_out(nv_write),
        .nv_data_out(nv_data), .write_target_control_out(ctrl));

    always #5 clk_in = ~clk_in;
    always @(negedge clk_in) if (nv_write === 1'b1) nv_pulses++;

    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        if (err_total == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic send(input logic [7:0] q[$], input logic exp_ack, input logic do_stop);
        logic a;
        gdc_master_model_i.start();
        foreach (q[i]) begin
            gdc_master_model_i.wr_byte(q[i], a);
            check(64'(a), 64'(exp_ack));
        end
        if (do_stop) begin
            gdc_master_model_i.stop();
        end
    endtask
    // dummy write sets the address, repeated start turns it into a read
    task automatic rd(input logic [7:0] mem, input logic [7:0] q[$]);
        logic [7:0] d;
        send('{8'hE8, mem}, 1'b0, 1'b0);
        send('{8'hE9}, 1'b0, 1'b0);
        foreach (q[i]) begin
            gdc_master_model_i.rd_byte(i == q.size() - 1, d);
            check(64'(d), 64'(q[i]));
        end
        check(64'(sda_oe_n), 64'h1);
        gdc_master_model_i.stop();
    endtask

    task automatic t_reset;
        check(64'(ctrl), 64'h00);
        check(64'({nv_busy, sda_oe_n}), 64'h1);
    endtask
    task automatic t_control;
        send('{8'hE8, 8'h08, 8'hFF}, 1'b0, 1'b1);
        tick(8);
        check(64'(ctrl), 64'h80);
        rd(8'h08, '{8'h80});
    endtask
    // working-only mode; page wrap from 03h back to 00h
    task automatic t_page;
        send('{8'hE8, 8'h02, 8'h11, 8'h22, 8'h33}, 1'b0, 1'b0);
        check(chan, {8{8'h80}});
        gdc_master_model_i.stop();
        tick(8);
        check(chan, 64'h80808080_22118033);
        check(64'(nv_pulses), 64'h0);
        rd(8'h00, '{8'h33, 8'h80, 8'h11, 8'h22});
    endtask
    task automatic t_nv;
        int n;
        send('{8'hE8, 8'h08, 8'h00}, 1'b0, 1'b1);
        send('{8'hE8, 8'h05, 8'hA5}, 1'b0, 1'b1);
        tick(8);
        check(64'(nv_busy), 64'h1);
        check(64'(nv_data[47:40]), 64'hA5);
        check(64'(nv_pulses), 64'h1);
        check(chan, 64'h8080A580_22118033);
        send('{8'hE8}, 1'b1, 1'b1);
        n = 0;
        while (nv_busy !== 1'b0 && n < 3000) begin
            tick(1);
            n++;
        end
        if (n == 3000) begin
            err_total++;
            finish_test();
        end
        send('{8'hE8}, 1'b0, 1'b1);
    endtask
    // foreign address stays silent; strap moves the address
    task automatic t_addr;
        send('{8'hEA, 8'h00, 8'h55}, 1'b1, 1'b1);
        tick(8);
        check(chan, 64'h8080A580_22118033);
        strap = 1'b1;
        send('{8'hEA, 8'h00, 8'h55}, 1'b0, 1'b1);
        tick(8);
        check(chan, 64'h8080A580_22118055);
    endtask

    initial begin
        clk_in = 1'b0;
        srst_in = 1'b1;
        strap = 1'b0;
        err_total = 0;
        samples_checked = 0;
        nv_pulses = 0;
        tick(10);
        srst_in = 1'b0;
        tick(4);
        t_reset();
        t_control();
        t_page();
        t_nv();
        t_addr();
        finish_test();
    end
endmodule
`default_nettype wire
